// file: hdl/lcdmv_ctrl.sv
// Memory-control and voltage-control register bank of the segment LCD driver
`include "lcdmv_regs.svh"
module lcdmv_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] blink_scheme,
  input wire logic [2:0] mux_mode,
  input wire logic blink_phase,
  input wire logic frame_boundary,
  input wire logic low_pin_present,
  output logic segment_mem_wipe_req,
  output logic blink_mem_wipe_req,
  input wire logic segment_mem_wipe_done,
  input wire logic blink_mem_wipe_done,
  output logic display_source_select,
  output lcdmv_pkg::lcdmv_analog_t analog
);

  // Overview of this bank
  // Two 16-bit registers sit in the low half of the APB data word
  // Memory control holds two wipe strobes and the display select
  // Voltage control holds the analog settings of the drive supply
  // Wipe strobes read back as busy until the far side finishes
  // A wipe waits for a frame boundary so no frame shows half-cleared data
  // Display select is owned by software only while blinking is off
  // In every other blink scheme hardware forces or follows it
  // Analog fields pass through with only the gating the rules need
  // Settings are not shadowed: software keeps the display off while changing them
  // Limitation: only byte lanes 0 and 1 of pstrb matter
  // Limitation: a memory-control write needs lane 0, where all its bits live
  // Trade-off: no wait states, so every access takes two cycles
  // Trade-off: read data is latched at setup, costing one row of flops
  // Hazard: blink_scheme and mux_mode are taken as synchronous levels
  // Hazard: a wipe strobe written while one runs is not queued


  // Access phase of a transfer; slave answers with no wait state
  logic acc; // Access phase of any transfer
  logic wr; // Access phase of a write
  logic sel_mem; // Address hits memory control
  logic sel_vctl; // Address hits voltage control

  // Decode is a plain compare against the two offsets
  // Any other address is refused with an error
  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign sel_mem = (paddr == `LCDMV_MEMCTL_OFF);
  assign sel_vctl = (paddr == `LCDMV_VCTL_OFF);
  assign pready = 1'b1;
  // Unmapped addresses answer with an error
  assign pslverr = acc && !(sel_mem || sel_vctl);


  // Byte-lane merge of a 16-bit register under strobe
  // Lanes 2 and 3 never reach these registers
  // The mask clears reserved bits on every write
  function automatic logic [15:0] lcdmv_merge(input logic [15:0] old,
                                              input logic [31:0] wd,
                                              input logic [3:0] st,
                                              input logic [15:0] mask);
    logic [15:0] m;
    m = old;
    if (st[0]) begin
      m[7:0] = wd[7:0];
    end
    if (st[1]) begin
      m[15:8] = wd[15:8];
    end
    lcdmv_merge = m & mask;
  endfunction : lcdmv_merge


  // Mux five or more
  // Blink memory is unused there, so its wipe and select are disabled
  logic high_mux;
  assign high_mux = (mux_mode >= `LCDMV_MUX_HIGH_MIN);


  // Write data for the memory-control register
  // The register holds no stored wipe bits, so merge starts from zero
  logic [15:0] mem_wd; // Masked write word
  logic mem_we; // Write strobe with lane 0 present
  assign mem_wd = lcdmv_merge(16'h0000, pwdata, pstrb, `LCDMV_MEMCTL_MASK);
  assign mem_we = wr && sel_mem && pstrb[0];


  // Voltage-control register; reserved bits masked on write
  // Writes take effect at once; no sequencing against display on
  logic [15:0] vctl_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vctl_q <= `LCDMV_VCTL_RST;
    end else if (wr && sel_vctl) begin
      vctl_q <= lcdmv_merge(vctl_q, pwdata, pstrb, `LCDMV_VCTL_MASK);
    end
  end


  // Segment memory wipe: wait for frame boundary, then for done
  // Idle: nothing pending, bit reads 0
  // Wait: strobe accepted, bit reads 1, no request yet
  // Run: request to the memory, held until done is seen
  // Waiting for a boundary keeps a frame from showing torn contents
  lcdmv_pkg::lcdmv_wipe_t seg_st_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seg_st_q <= lcdmv_pkg::LCDMV_W_IDLE;
    end else begin
      case (seg_st_q)
        lcdmv_pkg::LCDMV_W_IDLE: begin
          // Writing zero never starts or stops a wipe
          if (mem_we && mem_wd[`LCDMV_BIT_SEG_WIPE]) begin
            seg_st_q <= lcdmv_pkg::LCDMV_W_WAIT;
          end
        end
        lcdmv_pkg::LCDMV_W_WAIT: begin
          // Start only on a frame boundary
          if (frame_boundary) begin
            seg_st_q <= lcdmv_pkg::LCDMV_W_RUN;
          end
        end
        lcdmv_pkg::LCDMV_W_RUN: begin
          // Done ends the wipe and self-clears the bit
          if (segment_mem_wipe_done) begin
            seg_st_q <= lcdmv_pkg::LCDMV_W_IDLE;
          end
        end
        default: begin
          seg_st_q <= lcdmv_pkg::LCDMV_W_IDLE;
        end
      endcase
    end
  end
  assign segment_mem_wipe_req = (seg_st_q == lcdmv_pkg::LCDMV_W_RUN);


  // Blink memory wipe; in high mux the bit never sets
  // Same three steps as the segment wipe
  // In high mux the strobe is never taken; a wipe accepted before high mux still runs and reads 1
  lcdmv_pkg::lcdmv_wipe_t blk_st_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blk_st_q <= lcdmv_pkg::LCDMV_W_IDLE;
    end else begin
      case (blk_st_q)
        lcdmv_pkg::LCDMV_W_IDLE: begin
          if (mem_we && mem_wd[`LCDMV_BIT_BLINK_WIPE] && !high_mux) begin
            blk_st_q <= lcdmv_pkg::LCDMV_W_WAIT;
          end
        end
        lcdmv_pkg::LCDMV_W_WAIT: begin
          // Start only on a frame boundary
          if (frame_boundary) begin
            blk_st_q <= lcdmv_pkg::LCDMV_W_RUN;
          end
        end
        lcdmv_pkg::LCDMV_W_RUN: begin
          // Done ends the wipe and self-clears the bit
          if (blink_mem_wipe_done) begin
            blk_st_q <= lcdmv_pkg::LCDMV_W_IDLE;
          end
        end
        default: begin
          blk_st_q <= lcdmv_pkg::LCDMV_W_IDLE;
        end
      endcase
    end
  end
  assign blink_mem_wipe_req = (blk_st_q == lcdmv_pkg::LCDMV_W_RUN);


  // Stored display select, software-owned only in scheme 00 at low mux
  logic disp_q; // Stored select
  logic [1:0] scheme_q; // Scheme of the previous cycle, to see a return to 00

  // Previous scheme, for the return-to-off edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scheme_q <= 2'h0;
    end else begin
      scheme_q <= blink_scheme;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      disp_q <= 1'b0;
    end else if (blink_scheme == lcdmv_pkg::LCDMV_BLINK_INDIV
                 || blink_scheme == lcdmv_pkg::LCDMV_BLINK_ALL || high_mux) begin
      // Single-segment or whole-display blink, or high mux: forced low
      disp_q <= 1'b0;
    end else if (blink_scheme == lcdmv_pkg::LCDMV_BLINK_ALT) begin
      // Alternating scheme: stored value kept, writes ignored
      disp_q <= disp_q;
    end else if (scheme_q != lcdmv_pkg::LCDMV_BLINK_OFF) begin
      // First cycle back in scheme 00 clears the stored select
      disp_q <= 1'b0;
    end else if (mem_we) begin
      disp_q <= mem_wd[`LCDMV_BIT_DISP_SEL];
    end
  end


  // Displayed source: 0 segment memory, 1 blink memory
  // Combinational so the alternation is seen without a cycle of lag
  always_comb begin
    if (high_mux) begin
      display_source_select = 1'b0;
    end else begin
      case (blink_scheme)
        lcdmv_pkg::LCDMV_BLINK_ALT: display_source_select = blink_phase;
        lcdmv_pkg::LCDMV_BLINK_OFF: display_source_select = disp_q;
        default: display_source_select = 1'b0;
      endcase
    end
  end


  // Memory-control readback with live wipe flags
  // Wipe bits read 1 from the accepted strobe until done
  logic [15:0] mem_rd;
  always_comb begin
    mem_rd = 16'h0000;
    mem_rd[`LCDMV_BIT_BLINK_WIPE] = (blk_st_q != lcdmv_pkg::LCDMV_W_IDLE);
    mem_rd[`LCDMV_BIT_SEG_WIPE] = (seg_st_q != lcdmv_pkg::LCDMV_W_IDLE);
    mem_rd[`LCDMV_BIT_DISP_SEL] = display_source_select;
  end


  // Read data registered on the setup cycle so it is stable in access
  // Unmapped reads return zero along with the error response
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      if (sel_mem) begin
        prdata <= {16'h0000, mem_rd};
      end else if (sel_vctl) begin
        prdata <= {16'h0000, vctl_q};
      end else begin
        prdata <= 32'h00000000;
      end
    end
  end


  // Analog controls; the settings themselves are software's to sequence
  // Gating here only removes combinations that make no sense
  // External bias also switches the internal bias generator off
  always_comb begin
    analog.pump_level = vctl_q[`LCDMV_PUMP_LEVEL_HI:`LCDMV_PUMP_LEVEL_LO];
    // Pump needs pump_on, internal supply and a nonzero setting
    analog.pump_enable = vctl_q[`LCDMV_BIT_PUMP_ON] && !vctl_q[`LCDMV_BIT_EXT_SUPPLY]
      && (vctl_q[12:9] != 4'h0 || vctl_q[2:1] != 2'h0);
    analog.pump_reference_select = vctl_q[`LCDMV_PUMP_REF_HI:`LCDMV_PUMP_REF_LO];
    // Pin routing is meaningless with external bias
    analog.mid_levels_to_pins = vctl_q[`LCDMV_BIT_MID_PINS]
      && !vctl_q[`LCDMV_BIT_EXT_BIAS];
    analog.low_level_from_pin = vctl_q[`LCDMV_BIT_LOW_PIN] && low_pin_present;
    analog.internal_bias_on = !vctl_q[`LCDMV_BIT_EXT_BIAS];
    analog.drive_supply_external = vctl_q[`LCDMV_BIT_EXT_SUPPLY];
    analog.half_bias_select = vctl_q[`LCDMV_BIT_HALF_BIAS];
  end

endmodule : lcdmv_ctrl

// file: shared/lcdmv_regs.svh
// Register offsets, field positions, write masks, reset values and the high-mux threshold
// Operation
// - Blink wipe clears blink memory, self-clears
// - Blink wipe ignored at five-mux and above
// - Segment wipe clears segment memory, self-clears
// - Display select: 0 segment, 1 blink
// - Select forced zero in schemes 01/10, high mux
// - Scheme 11: select shows alternating memory
// - Returning to scheme 00 clears select
// - Pump level bits 12-9, zero disables unless pump reference bits 2-1 are nonzero
// - Pump runs only with pump_on set
// - Bit 7 mid levels to pins, internal bias
// - Bit 6 low level from pin if present
// - Bit 5 external bias, internal generator off
// - Bit 4 drive supply external when set
// - Blink scheme encoding off, individual, all, alternate
`ifndef LCDMV_REGS_SVH
`define LCDMV_REGS_SVH
`define LCDMV_MEMCTL_OFF 12'h000
`define LCDMV_VCTL_OFF 12'h004
`define LCDMV_MEMCTL_MASK 16'h0007
`define LCDMV_VCTL_MASK 16'h1EFF
`define LCDMV_MEMCTL_RST 16'h0000
`define LCDMV_VCTL_RST 16'h0000
`define LCDMV_BIT_BLINK_WIPE 2
`define LCDMV_BIT_SEG_WIPE 1
`define LCDMV_BIT_DISP_SEL 0
`define LCDMV_PUMP_LEVEL_HI 12
`define LCDMV_PUMP_LEVEL_LO 9
`define LCDMV_BIT_MID_PINS 7
`define LCDMV_BIT_LOW_PIN 6
`define LCDMV_BIT_EXT_BIAS 5
`define LCDMV_BIT_EXT_SUPPLY 4
`define LCDMV_BIT_PUMP_ON 3
`define LCDMV_PUMP_REF_HI 2
`define LCDMV_PUMP_REF_LO 1
`define LCDMV_BIT_HALF_BIAS 0
`define LCDMV_MUX_HIGH_MIN 3'h4
`endif

// file: shared/lcdmv_pkg.sv
// Types shared by the memory and voltage control block
package lcdmv_pkg;
  // Blink scheme encoding
  typedef enum logic [1:0] {
    LCDMV_BLINK_OFF = 2'b00,
    LCDMV_BLINK_INDIV = 2'b01,
    LCDMV_BLINK_ALL = 2'b10,
    LCDMV_BLINK_ALT = 2'b11
  } lcdmv_blink_t;
  // Wipe sequencer states
  typedef enum logic [1:0] {
    LCDMV_W_IDLE = 2'b00,
    LCDMV_W_WAIT = 2'b01,
    LCDMV_W_RUN = 2'b10
  } lcdmv_wipe_t;
  // Analog control outputs
  typedef struct packed {
    logic [3:0] pump_level;
    logic pump_enable;
    logic [1:0] pump_reference_select;
    logic mid_levels_to_pins;
    logic low_level_from_pin;
    logic internal_bias_on;
    logic drive_supply_external;
    logic half_bias_select;
  } lcdmv_analog_t;
endpackage : lcdmv_pkg

// file: testbench/lcdmv_ctrl_assertions.sv
// Port-level checks for the memory and voltage control block
module lcdmv_ctrl_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic pslverr,
  input wire logic [1:0] blink_scheme,
  input wire logic [2:0] mux_mode,
  input wire logic blink_phase,
  input wire logic frame_boundary,
  input wire logic low_pin_present,
  input wire logic segment_mem_wipe_req,
  input wire logic blink_mem_wipe_req,
  input wire logic segment_mem_wipe_done,
  input wire logic display_source_select,
  input wire lcdmv_pkg::lcdmv_analog_t analog
);
  // All checks live in the APB clock domain
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Wipe steps: still busy, then acknowledged
  sequence s_seg_busy;
    segment_mem_wipe_req && !segment_mem_wipe_done;
  endsequence
  sequence s_seg_end;
    segment_mem_wipe_req && segment_mem_wipe_done;
  endsequence
  a_seg_hold: assert property (s_seg_busy |=> segment_mem_wipe_req)
    else $error("segment wipe request dropped early");
  a_seg_release: assert property (s_seg_end |=> !segment_mem_wipe_req)
    else $error("segment wipe request outlived its done");
  a_seg_frame: assert property ($rose(segment_mem_wipe_req) |-> $past(frame_boundary))
    else $error("segment wipe started off a frame boundary");
  a_blink_start: assert property ($rose(blink_mem_wipe_req) |->
    $past(frame_boundary) && $past(mux_mode) < 3'h4)
    else $error("blink wipe started wrongly");
  a_sel_forced: assert property ((blink_scheme inside {2'b01, 2'b10} || mux_mode >= 3'h4)
    |-> !display_source_select)
    else $error("display select not forced low");
  a_sel_alt: assert property (blink_scheme == 2'b11 && mux_mode < 3'h4
    |-> display_source_select == blink_phase)
    else $error("display select does not track alternation");
  a_pump_gate: assert property (analog.pump_enable |-> !analog.drive_supply_external
    && (analog.pump_level != 4'h0 || analog.pump_reference_select != 2'h0))
    else $error("pump enabled without its conditions");
  a_low_pin: assert property (analog.low_level_from_pin |-> low_pin_present)
    else $error("low level routed to a missing pin");
  a_err_map: assert property (psel && penable
    |-> pslverr == !(paddr inside {12'h000, 12'h004}))
    else $error("error response wrong for address");
endmodule : lcdmv_ctrl_assertions

// file: testbench/lcdmv_glass_model.sv
// Far-side model: frame pacing and memory wipe acknowledgement
module lcdmv_glass_model #(parameter int DLY = 3) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic segment_mem_wipe_req,
  input wire logic blink_mem_wipe_req,
  output logic frame_boundary,
  output logic segment_mem_wipe_done,
  output logic blink_mem_wipe_done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] fcnt_q; // Frame divider, boundary every 8 cycles
  logic [3:0] scnt_q; // Cycles spent wiping segment memory
  logic [3:0] bcnt_q; // Cycles spent wiping blink memory
  // Wipe counters restart whenever a request is withdrawn; the frame divider free-runs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fcnt_q <= 3'h0;
      scnt_q <= 4'h0;
      bcnt_q <= 4'h0;
    end else begin
      fcnt_q <= fcnt_q + 3'h1;
      scnt_q <= segment_mem_wipe_req ? scnt_q + 4'h1 : 4'h0;
      bcnt_q <= blink_mem_wipe_req ? bcnt_q + 4'h1 : 4'h0;
    end
  end
  assign frame_boundary = (fcnt_q == 3'h7);
  // Done held as a level until the request falls, so a slow release still sees it
  assign segment_mem_wipe_done = segment_mem_wipe_req && scnt_q >= 4'(DLY);
  assign blink_mem_wipe_done = blink_mem_wipe_req && bcnt_q >= 4'(DLY);
endmodule : lcdmv_glass_model

// file: testbench/lcd_memory_and_voltage_control_tb.sv
// Register-level test of the memory and voltage control block
module lcd_memory_and_voltage_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic [3:0] pstrb = 4'hF; // Full lanes, strobes are not under test
  logic pready, pslverr, rerr, blink_phase = 1'b0, low_pin_present = 1'b1;
  logic clr_seen = 1'b0; // Clears the request latch, single driver of seen
  logic [1:0] blink_scheme = 2'b00;
  logic [2:0] mux_mode = 3'h0, seen = 3'h0; // Seen latches wipe requests
  logic frame_boundary, segment_mem_wipe_req, blink_mem_wipe_req;
  logic segment_mem_wipe_done, blink_mem_wipe_done, display_source_select;
  lcdmv_pkg::lcdmv_analog_t analog;
  int n_mismatch = 0, comparisons = 0;
  lcdmv_ctrl i_lcdmv_ctrl (.*);
  lcdmv_glass_model i_lcdmv_glass_model (.*);
  always #4 pclk = ~pclk;
  always @(posedge pclk)
    seen <= clr_seen ? 3'h0 : seen | {blink_mem_wipe_req, segment_mem_wipe_req, 1'b0};
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // One APB transfer; an extra edge lets written state settle
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rdat = prdata;
    rerr = pslverr;
    {psel, penable} <= 2'b00;
    @(posedge pclk);
  endtask : xfer
  // Start a wipe, see it pending, poll until the bit self-clears
  task automatic wipe(input int b);
    int n = 0;
    xfer(1'b1, 12'h000, 32'h1 << b);
    xfer(1'b0, 12'h000, 32'h0);
    chk("wipe pending", 32'(rdat[b]), 32'h1);
    while (rdat[b] !== 1'b0 && n < 30) begin
      xfer(1'b0, 12'h000, 32'h0);
      n++;
    end
    chk("wipe done", 32'(rdat[b]), 32'h0);
    chk("wipe request", 32'(seen[b]), 32'h1);
  endtask : wipe
  initial begin
    #200000;
    n_mismatch++;
    conclude();
  end
  initial begin
    logic [1:0] sch[3] = '{2'b01, 2'b10, 2'b00};
    logic [2:0] mx[3] = '{3'h0, 3'h0, 3'h4};
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    xfer(1'b0, 12'h000, 32'h0);
    chk("memctl reset", rdat, 32'h0);
    xfer(1'b0, 12'h004, 32'h0);
    chk("vctl reset", rdat, 32'h0);
    chk("bias on", 32'(analog.internal_bias_on), 32'h1);
    xfer(1'b1, 12'h004, 32'hFFFFFFFF);
    xfer(1'b0, 12'h004, 32'h0);
    chk("vctl mask", rdat, 32'h00001EFF);
    chk("mid pins ext bias", 32'(analog.mid_levels_to_pins), 32'h0);
    chk("supply ext", 32'(analog.drive_supply_external), 32'h1);
    chk("pump ref", 32'(analog.pump_reference_select), 32'h3);
    chk("half bias", 32'(analog.half_bias_select), 32'h1);
    chk("level", 32'(analog.pump_level), 32'hF);
    chk("ext supply", 32'(analog.pump_enable), 32'h0);
    chk("ext bias", 32'(analog.internal_bias_on), 32'h0);
    chk("low pin", 32'(analog.low_level_from_pin), 32'h1);
    low_pin_present <= 1'b0;
    xfer(1'b1, 12'h004, 32'h00000008);
    chk("no pin", 32'(analog.low_level_from_pin), 32'h0);
    chk("level zero", 32'(analog.pump_enable), 32'h0);
    xfer(1'b1, 12'h004, 32'h00000208);
    chk("pump on", 32'(analog.pump_enable), 32'h1);
    xfer(1'b1, 12'h004, 32'h00000200);
    chk("pump off", 32'(analog.pump_enable), 32'h0);
    xfer(1'b1, 12'h004, 32'h00000080);
    chk("mid pins", 32'(analog.mid_levels_to_pins), 32'h1);
    chk("supply int", 32'(analog.drive_supply_external), 32'h0);
    xfer(1'b0, 12'h008, 32'h0);
    chk("unmapped err", 32'(rerr), 32'h1);
    chk("unmapped data", rdat, 32'h0);
    wipe(1);
    wipe(2);
    mux_mode <= 3'h4;
    clr_seen <= 1'b1;
    @(posedge pclk);
    clr_seen <= 1'b0;
    xfer(1'b1, 12'h000, 32'h4);
    xfer(1'b0, 12'h000, 32'h0);
    chk("high mux wipe", rdat, 32'h0);
    repeat (12) @(posedge pclk);
    chk("high mux req", 32'(seen[2]), 32'h0);
    mux_mode <= 3'h0;
    xfer(1'b1, 12'h000, 32'h1);
    chk("select blink", 32'(display_source_select), 32'h1);
    for (int i = 0; i < 3; i++) begin
      blink_scheme <= sch[i];
      mux_mode <= mx[i];
      xfer(1'b1, 12'h000, 32'h1);
      chk("select forced", 32'(display_source_select), 32'h0);
      xfer(1'b0, 12'h000, 32'h0);
      chk("select read", rdat, 32'h0);
    end
    mux_mode <= 3'h0;
    xfer(1'b1, 12'h000, 32'h1);
    blink_scheme <= 2'b11;
    xfer(1'b0, 12'h000, 32'h0);
    chk("alt segment", 32'(display_source_select), 32'h0);
    blink_phase <= 1'b1;
    xfer(1'b1, 12'h000, 32'h0);
    chk("alt blink", 32'(display_source_select), 32'h1);
    blink_scheme <= 2'b00;
    blink_phase <= 1'b0;
    repeat (3) @(posedge pclk);
    chk("back to off", 32'(display_source_select), 32'h0);
    conclude();
  end
endmodule : lcd_memory_and_voltage_control_tb
bind lcdmv_ctrl lcdmv_ctrl_assertions i_lcdmv_ctrl_assertions (.*);
